// >>> port_j.v
// eight-pin bidirectional port with memory bus override and ahb-lite register slave
`timescale 1ns/1ps
`include "port_j_defs.vh"

// Behaviour
// - eight pins, per-bit direction, zero drives
// - reset leaves every pin an input
// - clearing bus disable hands pins over, except in the reduced variant
// - direction bits ignored while bus owns
// - one shared bit enables all pull-ups
// - pull-up off on any output pin
// - pull-ups off after reset
// - pin 0 carries address latch enable
// - pin 1 carries active-low output enable
// - pin 2 carries low byte write strobe
// - pin 3 carries high byte write strobe
// - pin 4 carries byte address bit zero
// - pin 5 carries chip enable
// - pin 6 carries lower byte enable
// - pin 7 carries upper byte enable
// - reduced variant: port registers read zero
module port_j (
	input wire hclk,
	input wire hresetn,
	input wire hsel,
	input wire [11:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output reg [31:0] hrdata,
	output reg hreadyout,
	output reg hresp,
	input wire [7:0] pin_in,
	output reg [7:0] pin_out,
	output reg [7:0] pin_oe,
	output reg [7:0] pin_pullup,
	input wire mem_ale,
	input wire mem_oe_n,
	input wire write_strobe_low_byte,
	input wire write_strobe_high_byte,
	input wire byte_addr_zero,
	input wire mem_ce,
	input wire lower_byte_select,
	input wire upper_byte_select,
	output reg mem_bus_active
);

	reg [7:0] port_j_output_latch;
	reg [7:0] port_j_direction;
	reg [7:0] port_g_pins_and_pullups;
	reg [7:0] memory_interface_control;
	reg reduced_variant;
	reg [7:0] pin_meta;
	reg [7:0] pin_sync;
	reg wr_pend;
	reg [11:0] wr_addr;
	wire port_j_pullup_enable;
	wire external_bus_disable;
	wire bus_owns;
	wire port_absent;
	wire [7:0] mem_signals;
	reg [31:0] next_hrdata;
	wire take;
	wire [7:0] next_out;
	wire [7:0] next_oe;
	wire [7:0] next_pu;
	// one write select per register word, live only in the data phase
	wire wr_pins;
	wire wr_latch;
	wire wr_dir;
	wire wr_port_g;
	wire wr_mem_ctrl;
	wire wr_variant;
	// pin slice index for the per-pin drive logic
	genvar gi;

	// decode a word address into a register select
	function is_reg;
		input [11:0] addr;
		input [11:0] off;
		begin
			is_reg = (addr[11:2] == off[11:2]);
		end
	endfunction

	assign port_j_pullup_enable = port_g_pins_and_pullups[`BIT_PULLUP_EN];
	assign external_bus_disable = memory_interface_control[`BIT_EXT_BUS_DIS];
	assign bus_owns = ~external_bus_disable & ~reduced_variant;
	assign port_absent = reduced_variant;
	assign take = hsel & hready & htrans[1];

	// memory interface controls, one pin each; the bus owns all eight together
	assign mem_signals[`PIN_ALE] = mem_ale;
	assign mem_signals[`PIN_OE_N] = mem_oe_n;
	assign mem_signals[`PIN_WR_LOW] = write_strobe_low_byte;
	assign mem_signals[`PIN_WR_HIGH] = write_strobe_high_byte;
	assign mem_signals[`PIN_BYTE_ADDR] = byte_addr_zero;
	assign mem_signals[`PIN_CE] = mem_ce;
	assign mem_signals[`PIN_LOWER_SEL] = lower_byte_select;
	assign mem_signals[`PIN_UPPER_SEL] = upper_byte_select;

	// two-flop synchroniser; the first stage feeds only the second
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			pin_meta <= 8'h00;
			pin_sync <= 8'h00;
		end
		else
		begin
			pin_meta <= pin_in;
			pin_sync <= pin_meta;
		end
	end

	// ahb-lite slave: zero wait states, always okay
	// the write address is held over because hwdata only arrives in the data phase
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wr_pend <= 1'b0;
			wr_addr <= 12'h000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
		else
		begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			if (hready)
			begin
				wr_pend <= take & hwrite;
				wr_addr <= haddr;
			end
		end
	end

	// write strobes per register word, valid for the one data-phase cycle
	// decoded once here so every register block sees the same select
	assign wr_pins = wr_pend & is_reg(wr_addr, `OFF_PIN_LEVELS);
	assign wr_latch = wr_pend & is_reg(wr_addr, `OFF_OUTPUT_LATCH);
	assign wr_dir = wr_pend & is_reg(wr_addr, `OFF_DIRECTION);
	assign wr_port_g = wr_pend & is_reg(wr_addr, `OFF_PORT_G);
	assign wr_mem_ctrl = wr_pend & is_reg(wr_addr, `OFF_MEM_CTRL);
	assign wr_variant = wr_pend & is_reg(wr_addr, `OFF_VARIANT);

	// output latch: the pin word and the latch word both write it
	// choosing the reduced variant clears it, and while absent writes are dropped
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			port_j_output_latch <= `RST_LATCH;
		end
		else if (wr_variant && hwdata[0])
		begin
			port_j_output_latch <= 8'h00;
		end
		else if ((wr_pins || wr_latch) && !port_absent)
		begin
			port_j_output_latch <= hwdata[7:0];
		end
	end

	// direction: a set bit makes its pin an input, so reset leaves all eight as inputs
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			port_j_direction <= `RST_DIRECTION;
		end
		else if (wr_variant && hwdata[0])
		begin
			port_j_direction <= 8'h00;
		end
		else if (wr_dir && !port_absent)
		begin
			port_j_direction <= hwdata[7:0];
		end
	end

	// neighbouring port word; only the shared pull-up bit acts here, the rest is storage
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			port_g_pins_and_pullups <= `RST_PORT_G;
		end
		else if (wr_port_g)
		begin
			port_g_pins_and_pullups <= hwdata[7:0];
		end
	end

	// memory interface control; clearing the disable bit hands the pins to the bus unless the reduced variant is set
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			memory_interface_control <= `RST_MEM_CTRL;
		end
		else if (wr_mem_ctrl)
		begin
			memory_interface_control <= hwdata[7:0];
		end
	end

	// reduced-pin variant select; a build would tie this, software can set it here
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			reduced_variant <= `RST_VARIANT;
		end
		else if (wr_variant)
		begin
			reduced_variant <= hwdata[0];
		end
	end

	// read mux; unmapped words read zero, and the absent port reads zero as well
	// kept as a priority chain so each register word has exactly one decode
	always @*
	begin
		next_hrdata = 32'h00000000;
		if (is_reg(haddr, `OFF_PIN_LEVELS))
		begin
			// synchronised levels, so a read never sees a metastable bit
			if (!port_absent)
			begin
				next_hrdata = {24'h000000, pin_sync};
			end
		end
		else if (is_reg(haddr, `OFF_OUTPUT_LATCH))
		begin
			if (!port_absent)
			begin
				next_hrdata = {24'h000000, port_j_output_latch};
			end
		end
		else if (is_reg(haddr, `OFF_DIRECTION))
		begin
			if (!port_absent)
			begin
				next_hrdata = {24'h000000, port_j_direction};
			end
		end
		else if (is_reg(haddr, `OFF_PORT_G))
		begin
			next_hrdata = {24'h000000, port_g_pins_and_pullups};
		end
		else if (is_reg(haddr, `OFF_MEM_CTRL))
		begin
			next_hrdata = {24'h000000, memory_interface_control};
		end
		else if (is_reg(haddr, `OFF_VARIANT))
		begin
			next_hrdata = {31'h00000000, reduced_variant};
		end
		else
		begin
			next_hrdata = 32'h00000000;
		end
	end

	// read data is loaded at the end of the address phase and stands through the data phase
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			hrdata <= 32'h00000000;
		end
		else if (take && !hwrite)
		begin
			hrdata <= next_hrdata;
		end
	end

	// pin drive, one slice per pin: memory bus first, then the per-bit direction
	// the absent port drives nothing and pulls nothing, so its pins float as inputs
	generate
		for (gi = 0; gi < 8; gi = gi + 1)
		begin : pin_slice
			reg out_bit;
			reg oe_bit;
			reg pu_bit;
			// owner of this pin for the coming cycle
			always @*
			begin
				out_bit = 1'b0;
				oe_bit = 1'b0;
				pu_bit = 1'b0;
				if (port_absent)
				begin
					out_bit = 1'b0;
					oe_bit = 1'b0;
				end
				else if (bus_owns)
				begin
					// the bus drives regardless of the direction bit
					out_bit = mem_signals[gi];
					oe_bit = 1'b1;
				end
				else
				begin
					out_bit = port_j_output_latch[gi];
					oe_bit = ~port_j_direction[gi];
				end
				// a driven pin never keeps its pull-up; it would only fight the driver
				if (!port_absent)
				begin
					pu_bit = port_j_pullup_enable & ~oe_bit;
				end
			end
			assign next_out[gi] = out_bit;
			assign next_oe[gi] = oe_bit;
			assign next_pu[gi] = pu_bit;
		end
	endgenerate

	// registered pins; one cycle from a control change to the pin
	// every pin output comes straight from a flop so the pads never see decode glitches
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			pin_out <= 8'h00;
		end
		else
		begin
			pin_out <= next_out;
		end
	end

	// drivers off during and right after reset, so every pin starts as an input
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			pin_oe <= 8'h00;
		end
		else
		begin
			pin_oe <= next_oe;
		end
	end

	// pull-ups off during reset; they only come on once software enables them
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			pin_pullup <= 8'h00;
		end
		else
		begin
			pin_pullup <= next_pu;
		end
	end

	// ownership flag, one flop late like the pins that it describes
	always @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			mem_bus_active <= 1'b0;
		end
		else
		begin
			mem_bus_active <= bus_owns;
		end
	end

endmodule

// >>> port_j_defs.vh
// register offsets, field positions, reset values for the port j block
`ifndef PORT_J_DEFS_VH
`define PORT_J_DEFS_VH
`define OFF_PIN_LEVELS 12'h000
`define OFF_OUTPUT_LATCH 12'h004
`define OFF_DIRECTION 12'h008
`define OFF_PORT_G 12'h00c
`define OFF_MEM_CTRL 12'h010
`define OFF_VARIANT 12'h014
`define BIT_PULLUP_EN 5
`define BIT_EXT_BUS_DIS 7
`define RST_DIRECTION 8'hff
`define RST_LATCH 8'h00
`define RST_PORT_G 8'h00
`define RST_MEM_CTRL 8'h80
`define RST_VARIANT 1'b0
`define PIN_ALE 0
`define PIN_OE_N 1
`define PIN_WR_LOW 2
`define PIN_WR_HIGH 3
`define PIN_BYTE_ADDR 4
`define PIN_CE 5
`define PIN_LOWER_SEL 6
`define PIN_UPPER_SEL 7
`endif

// >>> port_j_sva.sv
// pin and bus checker for the port j block
`timescale 1ns/1ps
module port_j_sva (
	input wire hclk,
	input wire hresetn,
	input wire hreadyout,
	input wire hresp,
	input wire [7:0] pin_oe,
	input wire [7:0] pin_pullup,
	input wire mem_bus_active
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// pins and the ownership flag switch on the same edge; the run of three only adds margin
	sequence own; mem_bus_active [*3]; endsequence
	a_ready_high: assert property (hreadyout) else $error("wait state");
	a_resp_okay: assert property (!hresp) else $error("error resp");
	a_pu_out: assert property ((pin_pullup & pin_oe) == 8'h00) else $error("pu on out");
	a_rst_in: assert property ($rose(hresetn) |-> pin_oe == 8'h00) else $error("oe at rst");
	a_rst_pu: assert property ($rose(hresetn) |-> pin_pullup == 8'h00) else $error("pu at rst");
	a_bus_out: assert property (own |-> pin_oe == 8'hff) else $error("bus oe");
	a_bus_pu: assert property (own |-> pin_pullup == 8'h00) else $error("bus pu");
	a_take_pins: assert property ($rose(mem_bus_active) |-> ##[0:2] pin_oe == 8'hff) else $error("slow");
	c_bus: cover property (own);
	c_out: cover property (pin_oe != 8'h00 && !mem_bus_active);
	c_pu: cover property (pin_pullup != 8'h00);
endmodule
bind port_j port_j_sva port_j_sva_inst (.hclk, .hresetn, .hreadyout, .hresp, .pin_oe, .pin_pullup, .mem_bus_active);

// >>> mem_partner.sv
// far side: memory controller strobes and pin levels
`timescale 1ns/1ps
module mem_partner (
	input wire hclk,
	input wire [7:0] pin_out,
	input wire [7:0] pin_oe,
	input wire [7:0] pin_pullup,
	input wire [7:0] ext,
	output wire [7:0] pin_in,
	output reg [7:0] ctl = 8'h00
);
	// strobes step each cycle so a swapped pin shows
	always @(posedge hclk)
		ctl <= ctl + 8'h01;
	// driver wins, then pull-up, then outside level
	assign pin_in = pin_oe & pin_out | ~pin_oe & (pin_pullup | ext);
endmodule

// >>> port_j_tb.sv
// bench for the port j block
`timescale 1ns/1ps
module port_j_tb;
	reg hclk, hresetn, hsel, hwrite;
	reg [11:0] haddr;
	reg [1:0] htrans;
	reg [31:0] hwdata, q;
	reg [7:0] ext;
	integer failures, comparisons, cycles;
	wire [31:0] hrdata;
	wire [2:0] hsize = 3'h2;
	wire [7:0] pin_in, pin_out, pin_oe, pin_pullup, ctl;
	wire hreadyout, hresp, mem_bus_active;
	wire hready = hreadyout;
	wire mem_ale = ctl[0], mem_oe_n = ctl[1], write_strobe_low_byte = ctl[2], write_strobe_high_byte = ctl[3];
	wire byte_addr_zero = ctl[4], mem_ce = ctl[5], lower_byte_select = ctl[6], upper_byte_select = ctl[7];
	port_j port_j_inst (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata,
		.hreadyout, .hresp, .pin_in, .pin_out, .pin_oe, .pin_pullup, .mem_ale, .mem_oe_n, .write_strobe_low_byte,
		.write_strobe_high_byte, .byte_addr_zero, .mem_ce, .lower_byte_select, .upper_byte_select, .mem_bus_active);
	mem_partner mem_partner_inst (.hclk, .pin_out, .pin_oe, .pin_pullup, .ext, .pin_in, .ctl);
	// clock
	initial
	begin
		hclk = 1'b0;
		forever #25 hclk = ~hclk;
	end
	// hang guard, the run needs about 75 cycles
	always @(posedge hclk)
	begin
		cycles = cycles + 1;
		if (cycles == 1000)
			finish_test;
	end
	// one single word: address phase, then data phase
	task x(input w, input [11:0] a, input [7:0] d);
		@(posedge hclk);
		{hsel, haddr, htrans, hwrite} <= {1'b1, a, 2'h2, w};
		do @(posedge hclk); while (hready !== 1'b1);
		{hsel, htrans, hwdata} <= {1'b0, 2'h0, 24'h000000, d};
		do @(posedge hclk); while (hready !== 1'b1);
		q = hrdata;
	endtask
	task c(input [31:0] n, input [31:0] e, input [31:0] g);
		comparisons = comparisons + 1;
		if (g !== e)
			$display("unexpected %0s exp %h got %h", n, e, g);
		failures = failures + (g !== e);
	endtask
	task r(input [11:0] a, input [31:0] n, input [7:0] e);
		x(1'b0, a, 8'h00);
		c(n, {24'h000000, e}, q);
	endtask
	task finish_test;
		failures = failures + (cycles >= 1000);
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial
	begin
		{hresetn, hsel, hwrite, haddr, htrans, hwdata} = 0;
		ext = 8'h03;
		failures = 0;
		comparisons = 0;
		cycles = 0;
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		r(12'h008, "dir", 8'hff);
		r(12'h018, "map", 8'h00);
		c("pu", 8'h00, pin_pullup);
		$display("reset test done");
		x(1'b1, 12'h004, 8'ha5);
		x(1'b1, 12'h008, 8'h0f);
		repeat (3) @(negedge hclk);
		c("oe", 8'hf0, pin_oe);
		c("out", 8'ha0, pin_out & 8'hf0);
		r(12'h000, "pins", 8'ha3);
		x(1'b1, 12'h000, 8'h3c);
		r(12'h004, "lat", 8'h3c);
		x(1'b1, 12'h00c, 8'h20);
		repeat (3) @(negedge hclk);
		c("pu", 8'h0f, pin_pullup);
		$display("port test done");
		x(1'b1, 12'h010, 8'h00);
		repeat (4) @(negedge hclk);
		c("oe", 8'hff, pin_oe);
		c("pu", 8'h00, pin_pullup);
		c("bus", {24'h000000, ctl - 8'h01}, pin_out);
		c("act", 32'h00000001, mem_bus_active);
		x(1'b1, 12'h010, 8'h80);
		x(1'b1, 12'h00c, 8'h00);
		repeat (3) @(negedge hclk);
		c("act", 32'h00000000, mem_bus_active);
		c("oe", 8'hf0, pin_oe);
		c("pu", 8'h00, pin_pullup);
		$display("bus test done");
		x(1'b1, 12'h014, 8'h01);
		x(1'b1, 12'h004, 8'h55);
		r(12'h004, "lat", 8'h00);
		r(12'h008, "dir", 8'h00);
		r(12'h000, "pins", 8'h00);
		c("oe", 8'h00, pin_oe);
		$display("variant test done");
		finish_test;
	end
endmodule
